// ==== inc/shc_pkg.sv ====
// Shared constants and types of the standby and halt controller
package shc_pkg;
	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_KHZ = 250000; // 250 MHz reference clock
	localparam int unsigned MODE_FILTER_NS = 187500; // 187.5 us noise window
	localparam int unsigned CARRY_SHORT_MS = 5;
	localparam int unsigned CARRY_LONG_MS = 100;
	// Least time rounds up to whole cycles
	localparam int unsigned MODE_FILTER_CYCLES = (MODE_FILTER_NS * (CLK_KHZ / 1000) + 999) / 1000;
	localparam int unsigned CARRY_SHORT_CYCLES = CARRY_SHORT_MS * CLK_KHZ;
	localparam int unsigned CARRY_LONG_CYCLES = CARRY_LONG_MS * CLK_KHZ;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_IRQ_CTRL = 8'h00;
	localparam logic [7:0] IDX_IRQ_PEND = 8'h01;
	localparam logic [7:0] IDX_KEY = 8'h02;
	localparam logic [7:0] IDX_STATE = 8'h03;
	localparam logic [7:0] IDX_MODE = 8'h07;
	localparam logic [7:0] IDX_CARRY = 8'h17;

	// ==========================================================
	// Field positions
	localparam int unsigned IRQ_CTRL_GIE = 0;
	localparam int unsigned IRQ_CTRL_PERM_LSB = 1;
	localparam int unsigned KEY_ROUTE_EN = 4;
	localparam int unsigned KEY_ROUTE_LSB = 5;
	localparam int unsigned STATE_OP_LSB = 2;
	localparam int unsigned STATE_RST_PEND = 6;
	localparam int unsigned CARRY_FLAG = 0;
	localparam int unsigned CARRY_LONG_SEL = 1;

	// Halt operand bits
	localparam int unsigned OP_KEY = 0;
	localparam int unsigned OP_CARRY = 1;
	localparam int unsigned OP_IRQ = 3;

	// Interrupt sources, index order is hardware priority
	localparam logic [1:0] SRC_EXT = 2'h0;
	localparam logic [1:0] SRC_TIMER = 2'h1;
	localparam logic [1:0] SRC_VSYNC = 2'h2;
	localparam logic [1:0] SRC_SERIAL = 2'h3;

	// Reset values
	localparam logic [3:0] PERM_RESET = 4'h0;
	localparam logic [3:0] PULLDOWN_ON = 4'hF;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HALT = 2'b01,
		ST_STOP = 2'b10,
		ST_WAKE = 2'b11
	} shc_state_t;

	typedef struct packed {
		logic haltExec;
		logic stopExec;
		logic eiExec;
		logic diExec;
		logic retiExec;
		logic [3:0] operand;
	} shc_cpu_req_t;
endpackage

// ==== rtl/shc_standby_ctrl.sv ====
// Standby, halt and mode pin reset controller with APB register access
//
// Function
// RL1 - Mode pin levels shorter than 187.5 us are ignored.
// RL2 - Filtered mode level readable at bit 0 of register 07H.
// RL3 - Oscillator stop works only while filtered mode level is low, else no-op.
// RL4 - Rising filtered mode level triggers a mode pin reset.
// RL5 - That reset is applied at the next interval carry setting.
// RL6 - Software always gives the oscillator stop operand as 0000B.
// RL7 - Pause stops the CPU clock and holds the program counter there.
// RL8 - Pause works whatever the mode pin level.
// RL9 - Peripherals keep running, unchanged, during the pause.
// RL10 - Pause operand is a release mask; any enabled condition ends it.
// RL11 - Non-interrupt release continues with the next instruction.
// RL12 - Both resets end the pause; operand 0000B leaves only reset.
// RL13 - Operand 0001B releases on a high key input.
// RL14 - Key inputs have pull-downs always enabled.
// RL15 - One key pin may route to the converter; its latch holds.
// RL16 - Operand 0010B releases when the interval carry flag sets.
// RL17 - Interval carry flag at bit 0 of 17H, set every 5 or 100 ms.
// RL18 - Operand 1000B releases when an interrupt is accepted.
// RL19 - Interrupts need global enable and own permission to be accepted.
// RL20 - External pin, timer, vertical sync and serial can release the pause.
// RL21 - Interrupt release vectors; return resumes after the pause instruction.
// RL22 - External pin beats timer; pending timer is taken right after return.
// RL23 - Oscillator stop halts everything; a mode pin reset ends it.
// RL24 - Mode filter is a synchronous counter; edge detect uses filtered level.
`timescale 1ns/1ps
module shc_standby_ctrl #(
	parameter logic [31:0] FILTER_CYCLES = shc_pkg::MODE_FILTER_CYCLES,
	parameter logic [31:0] SHORT_CYCLES = shc_pkg::CARRY_SHORT_CYCLES,
	parameter logic [31:0] LONG_CYCLES = shc_pkg::CARRY_LONG_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic modePin,
	input wire logic [3:0] keyPins,
	input wire logic [3:0] irqIn,
	input wire shc_pkg::shc_cpu_req_t cpuReq,
	output logic cpuClkRun,
	output logic pcHold,
	output logic oscRun,
	output logic ctrlInit,
	output logic modeResetOut,
	output logic haltReleased,
	output logic irqTake,
	output logic [1:0] irqVector,
	output logic [3:0] keyPullDownEn,
	output logic [3:0] adcRouteSel
);
	// ==========================================================
	// Declarations
	shc_pkg::shc_state_t state;
	logic [31:0] filterCnt;
	logic modeLevel;
	logic modeLevelDly;
	logic rstPend;
	logic modeResetFire;
	logic softRst;
	logic [31:0] tmrCnt;
	logic carrySet;
	logic carryFlag;
	logic carryLong;
	logic gie;
	logic [3:0] perm;
	logic [3:0] pend;
	logic inService;
	logic [3:0] haltOp;
	logic [3:0] keyLatch;
	logic routeEn;
	logic [1:0] routeIdx;
	logic [3:0] eligible;
	logic acceptNow;
	logic [1:0] acceptSrc;
	logic releaseNow;
	logic setupRd;
	logic wrEn;
	logic [7:0] regIdx;
	logic mapped;
	logic [31:0] rdValue;

	// ==========================================================
	// Mode pin filter
	// A level counts only after staying put for the full window, so a short glitch restarts the count
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			filterCnt <= 32'h0;
			modeLevel <= 1'b0;
		end else if (modePin == modeLevel) begin
			filterCnt <= 32'h0; // RL1
		end else if (filterCnt >= FILTER_CYCLES - 32'h1) begin
			filterCnt <= 32'h0;
			modeLevel <= modePin; // RL24
		end else begin
			filterCnt <= filterCnt + 32'h1;
		end
	end

	// Edge detector on the filtered level only, never the raw pin
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			modeLevelDly <= 1'b0;
		end else begin
			modeLevelDly <= modeLevel; // RL24
		end
	end

	// Mode reset waits for the carry, so it lands on a known timer phase
	assign modeResetFire = rstPend && carrySet; // RL5
	assign softRst = reset || modeResetFire; // RL12

	always_ff @(posedge ref_clk) begin
		if (reset || modeResetFire) begin
			rstPend <= 1'b0;
		end else if (modeLevel && !modeLevelDly) begin
			rstPend <= 1'b1; // RL4
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			modeResetOut <= 1'b0;
		end else begin
			modeResetOut <= modeResetFire; // RL5
		end
	end

	// ==========================================================
	// Interval timer and carry flag
	// Runs in every state but the stopped one; the pause does not touch it
	always_ff @(posedge ref_clk) begin
		if (softRst) begin
			tmrCnt <= 32'h0;
		end else if (state == shc_pkg::ST_STOP) begin
			tmrCnt <= tmrCnt; // RL23
		end else if (carrySet) begin
			tmrCnt <= 32'h0;
		end else begin
			tmrCnt <= tmrCnt + 32'h1; // RL9
		end
	end

	assign carrySet = (state != shc_pkg::ST_STOP) &&
		(tmrCnt >= (carryLong ? LONG_CYCLES : SHORT_CYCLES) - 32'h1); // RL17

	// Hardware set beats a software clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (softRst) begin
			carryFlag <= 1'b0;
		end else if (carrySet) begin
			carryFlag <= 1'b1; // RL17
		end else if (wrEn && regIdx == shc_pkg::IDX_CARRY) begin
			carryFlag <= pwdata[shc_pkg::CARRY_FLAG];
		end
	end

	// ==========================================================
	// Key inputs
	// Pull-downs cannot be switched off by software
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			keyPullDownEn <= shc_pkg::PULLDOWN_ON;
		end else begin
			keyPullDownEn <= shc_pkg::PULLDOWN_ON; // RL14
		end
	end

	// A routed pin leaves its latch frozen; a high left there releases a key pause at once
	for (genvar i = 0; i < 4; i++) begin : g_key
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				keyLatch[i] <= 1'b0;
			end else if (!(routeEn && routeIdx == 2'(i))) begin
				keyLatch[i] <= keyPins[i]; // RL15
			end
		end
	end

	// One-hot selector means at most one pin reaches the converter
	always_ff @(posedge ref_clk) begin
		if (softRst) begin
			adcRouteSel <= 4'h0;
		end else begin
			adcRouteSel <= routeEn ? (4'h1 << routeIdx) : 4'h0; // RL15
		end
	end

	// ==========================================================
	// Interrupt acceptance
	// Lowest index wins; a source left pending is taken after the handler re-enables and returns
	assign eligible = pend & perm & {4{gie}} & {4{!inService}} &
		{4{(state == shc_pkg::ST_RUN) || (state == shc_pkg::ST_HALT && haltOp[shc_pkg::OP_IRQ])}}; // RL19
	assign acceptNow = |eligible; // RL20

	always_comb begin
		acceptSrc = shc_pkg::SRC_SERIAL;
		if (eligible[shc_pkg::SRC_EXT]) begin
			acceptSrc = shc_pkg::SRC_EXT; // RL22
		end else if (eligible[shc_pkg::SRC_TIMER]) begin
			acceptSrc = shc_pkg::SRC_TIMER;
		end else if (eligible[shc_pkg::SRC_VSYNC]) begin
			acceptSrc = shc_pkg::SRC_VSYNC;
		end
	end

	// Requests are sticky; a new request in the clearing cycle survives
	always_ff @(posedge ref_clk) begin
		if (softRst) begin
			pend <= 4'h0;
		end else begin
			for (int s = 0; s < 4; s++) begin
				if (irqIn[s]) begin
					pend[s] <= 1'b1;
				end else if (acceptNow && acceptSrc == 2'(s)) begin
					pend[s] <= 1'b0;
				end else if (wrEn && regIdx == shc_pkg::IDX_IRQ_PEND) begin
					pend[s] <= pwdata[s];
				end
			end
		end
	end

	// Acceptance drops global enable; the return instruction clears in-service, and an enable instruction reopens acceptance
	always_ff @(posedge ref_clk) begin
		if (softRst) begin
			gie <= 1'b0;
			inService <= 1'b0;
		end else begin
			if (acceptNow || cpuReq.diExec) begin
				gie <= 1'b0;
			end else if (cpuReq.eiExec) begin
				gie <= 1'b1;
			end else if (wrEn && regIdx == shc_pkg::IDX_IRQ_CTRL) begin
				gie <= pwdata[shc_pkg::IRQ_CTRL_GIE];
			end
			if (acceptNow) begin
				inService <= 1'b1;
			end else if (cpuReq.retiExec) begin
				inService <= 1'b0; // RL22
			end
		end
	end

	// Vector pulse; the CPU stacks the address after the pause for the return
	always_ff @(posedge ref_clk) begin
		if (softRst) begin
			irqTake <= 1'b0;
			irqVector <= 2'h0;
		end else begin
			irqTake <= acceptNow; // RL21
			irqVector <= acceptNow ? acceptSrc : irqVector;
		end
	end

	// ==========================================================
	// Standby state machine
	assign releaseNow = (haltOp[shc_pkg::OP_KEY] && |keyLatch) || // RL13
		(haltOp[shc_pkg::OP_CARRY] && carrySet) || // RL16
		(haltOp[shc_pkg::OP_IRQ] && acceptNow); // RL10 RL18

	always_ff @(posedge ref_clk) begin
		if (softRst) begin
			state <= shc_pkg::ST_RUN; // RL12
			haltOp <= 4'h0;
		end else begin
			case (state)
				shc_pkg::ST_RUN: begin
					if (cpuReq.haltExec) begin
						state <= shc_pkg::ST_HALT; // RL8
						haltOp <= cpuReq.operand;
					end else if (cpuReq.stopExec && !modeLevel) begin
						state <= shc_pkg::ST_STOP; // RL3
					end
				end
				shc_pkg::ST_HALT: begin
					if (releaseNow) begin
						state <= shc_pkg::ST_RUN; // RL11
					end
				end
				shc_pkg::ST_STOP: begin
					if (modeLevel && !modeLevelDly) begin
						state <= shc_pkg::ST_WAKE; // RL23
					end
				end
				default: begin
					state <= shc_pkg::ST_WAKE; // Waits for the pending mode reset
				end
			endcase
		end
	end

	// CPU clock and program counter freeze while not running
	always_ff @(posedge ref_clk) begin
		if (softRst) begin
			cpuClkRun <= 1'b1;
			pcHold <= 1'b0;
			oscRun <= 1'b1;
			haltReleased <= 1'b0;
			ctrlInit <= 1'b0;
		end else begin
			cpuClkRun <= (state == shc_pkg::ST_RUN && !cpuReq.haltExec &&
				!(cpuReq.stopExec && !modeLevel)) || (state == shc_pkg::ST_HALT && releaseNow); // RL7
			pcHold <= !((state == shc_pkg::ST_RUN && !cpuReq.haltExec &&
				!(cpuReq.stopExec && !modeLevel)) || (state == shc_pkg::ST_HALT && releaseNow));
			oscRun <= !(state == shc_pkg::ST_STOP || (state == shc_pkg::ST_RUN && !cpuReq.haltExec &&
				cpuReq.stopExec && !modeLevel)) || (state == shc_pkg::ST_STOP && modeLevel && !modeLevelDly);
			haltReleased <= (state == shc_pkg::ST_HALT) && releaseNow;
			ctrlInit <= (state == shc_pkg::ST_RUN) && !cpuReq.haltExec && cpuReq.stopExec && !modeLevel;
		end
	end

	// ==========================================================
	// Control registers
	// Stopping the oscillator puts the controls back to their initial values
	always_ff @(posedge ref_clk) begin
		if (softRst || ctrlInit) begin
			perm <= shc_pkg::PERM_RESET;
			routeEn <= 1'b0;
			routeIdx <= 2'h0;
			carryLong <= 1'b0;
		end else if (wrEn) begin
			if (regIdx == shc_pkg::IDX_IRQ_CTRL) begin
				perm <= pwdata[shc_pkg::IRQ_CTRL_PERM_LSB +: 4];
			end else if (regIdx == shc_pkg::IDX_KEY) begin
				routeEn <= pwdata[shc_pkg::KEY_ROUTE_EN];
				routeIdx <= pwdata[shc_pkg::KEY_ROUTE_LSB +: 2];
			end else if (regIdx == shc_pkg::IDX_CARRY) begin
				carryLong <= pwdata[shc_pkg::CARRY_LONG_SEL];
			end
		end
	end

	// ==========================================================
	// APB slave
	// Zero wait states: data is fetched in setup and handed out in access
	assign regIdx = {2'b00, paddr[7:2]};
	assign wrEn = psel && penable && pwrite && mapped;
	assign setupRd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		mapped = 1'b1;
		rdValue = 32'h0;
		if (paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end else if (regIdx == shc_pkg::IDX_IRQ_CTRL) begin
			rdValue = {27'h0, perm, gie};
		end else if (regIdx == shc_pkg::IDX_IRQ_PEND) begin
			rdValue = {28'h0, pend};
		end else if (regIdx == shc_pkg::IDX_KEY) begin
			rdValue = {25'h0, routeIdx, routeEn, keyLatch};
		end else if (regIdx == shc_pkg::IDX_STATE) begin
			rdValue = {25'h0, rstPend, haltOp, state};
		end else if (regIdx == shc_pkg::IDX_MODE) begin
			rdValue = {31'h0, modeLevel}; // RL2
		end else if (regIdx == shc_pkg::IDX_CARRY) begin
			rdValue = {30'h0, carryLong, carryFlag}; // RL17
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata <= 32'h0;
		end else if (setupRd) begin
			prdata <= rdValue;
		end
	end

	// ==========================================================
	// Checks
	AST_FILTER_WINDOW: assert property (@(posedge ref_clk) disable iff (reset) // RL1
		(modeLevel != $past(modeLevel)) |-> ($past(filterCnt) == FILTER_CYCLES - 32'h1 && $past(modePin) == modeLevel))
		else $error("Mode level changed before the filter window elapsed");
	AST_MODE_READ: assert property (@(posedge ref_clk) disable iff (reset) // RL2
		(setupRd && paddr == {shc_pkg::IDX_MODE[5:0], 2'b00}) |=> prdata[0] == $past(modeLevel))
		else $error("Mode flag read back wrong");
	AST_STOP_NOP: assert property (@(posedge ref_clk) disable iff (softRst) // RL3
		(state == shc_pkg::ST_RUN && cpuReq.stopExec && !cpuReq.haltExec && modeLevel) |=> state == shc_pkg::ST_RUN)
		else $error("Oscillator stop taken while mode level high");
	AST_STOP_TAKE: assert property (@(posedge ref_clk) disable iff (softRst) // RL23
		(state == shc_pkg::ST_RUN && cpuReq.stopExec && !cpuReq.haltExec && !modeLevel) |=> ##1 !oscRun && ctrlInit == 1'b0)
		else $error("Oscillator kept running after a valid stop");
	AST_RISE_PEND: assert property (@(posedge ref_clk) disable iff (reset) // RL4
		(modeLevel && !modeLevelDly && !carrySet) |=> rstPend)
		else $error("Filtered rising edge did not arm the mode reset");
	AST_RESET_AT_CARRY: assert property (@(posedge ref_clk) disable iff (reset) // RL5
		modeResetOut |-> ($past(rstPend) && $past(carrySet)))
		else $error("Mode reset not aligned to the carry");
	AST_HALT_ENTER: assert property (@(posedge ref_clk) disable iff (softRst) // RL7
		(state == shc_pkg::ST_RUN && cpuReq.haltExec) |=> (state == shc_pkg::ST_HALT && !cpuClkRun && pcHold))
		else $error("Pause did not freeze the CPU");
	AST_TIMER_RUNS: assert property (@(posedge ref_clk) disable iff (softRst) // RL9
		(state == shc_pkg::ST_HALT && !carrySet) |=> tmrCnt == $past(tmrCnt) + 32'h1)
		else $error("Interval timer stalled during pause");
	AST_ONLY_RESET: assert property (@(posedge ref_clk) disable iff (softRst) // RL12
		(state == shc_pkg::ST_HALT && haltOp == 4'h0) |=> state == shc_pkg::ST_HALT)
		else $error("Pause with empty mask left without reset");
	AST_KEY_RELEASE: assert property (@(posedge ref_clk) disable iff (softRst) // RL13
		(state == shc_pkg::ST_HALT && haltOp[shc_pkg::OP_KEY] && |keyLatch) |=> (state == shc_pkg::ST_RUN && haltReleased))
		else $error("High key input did not end the pause");
	AST_CARRY_RELEASE: assert property (@(posedge ref_clk) disable iff (softRst) // RL16
		(state == shc_pkg::ST_HALT && haltOp[shc_pkg::OP_CARRY] && carrySet) |=> (state == shc_pkg::ST_RUN && carryFlag))
		else $error("Carry setting did not end the pause");
	AST_IRQ_GATED: assert property (@(posedge ref_clk) disable iff (softRst) // RL19
		irqTake |-> ($past(gie) && $past(perm[acceptSrc]) && !$past(inService)))
		else $error("Interrupt accepted without enables");
	AST_EXT_FIRST: assert property (@(posedge ref_clk) disable iff (softRst) // RL22
		(eligible[shc_pkg::SRC_EXT] && eligible[shc_pkg::SRC_TIMER]) |=> (irqTake && irqVector == shc_pkg::SRC_EXT))
		else $error("Timer served ahead of external pin");
	AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (reset) // RL15
		(routeEn && $past(routeEn) && routeIdx == $past(routeIdx)) |-> keyLatch[routeIdx] == $past(keyLatch[routeIdx]))
		else $error("Routed key latch changed");
endmodule

// ==== verif/shc_far_side.sv ====
// Far-side model of the standby block: mode pin driver and key matrix
`timescale 1ns/1ps
module shc_far_side (
	input wire logic ref_clk,
	input wire logic modeCmd,
	input wire logic [3:0] keyCmd,
	input wire logic [3:0] keyDrv,
	output logic modePin = 1'b0,
	output logic [3:0] keyPins
);
	// ==========================================================
	// Mode pin
	// Pin moves only on a clock edge, so the filter sees whole-cycle levels
	always_ff @(posedge ref_clk) begin
		modePin <= modeCmd;
	end

	// ==========================================================
	// Key matrix
	// A released key falls to the pull-down level, never keeps its last value
	always_comb begin
		keyPins = keyCmd & keyDrv;
	end
endmodule

// ==== verif/standby_halt_control_tb_top.sv ====
// Self-checking testbench of the standby and halt controller
`timescale 1ns/1ps
module standby_halt_control_tb_top;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic modeCmd = 1'b0;
	logic [3:0] keyCmd = 4'h0;
	logic [3:0] keyDrv = 4'h0;
	logic modePin;
	logic [3:0] keyPins;
	logic [3:0] irqIn = 4'h0;
	shc_pkg::shc_cpu_req_t cpuReq = '0;
	logic cpuClkRun, pcHold, oscRun, ctrlInit, modeResetOut, haltReleased, irqTake;
	logic [1:0] irqVector;
	logic [1:0] lastVec = 2'h0;
	logic [3:0] keyPullDownEn, adcRouteSel;
	logic [31:0] rd;
	logic er;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int nRel = 0;
	int nTake = 0;
	int nMr = 0;
	int nInit = 0;

	// ==========================================================
	// Clock, models and design
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	shc_far_side u_far (.ref_clk(ref_clk), .modeCmd(modeCmd), .keyCmd(keyCmd), .keyDrv(keyDrv),
		.modePin(modePin), .keyPins(keyPins));

	// Short counts keep the run brief; expectations use the same values
	shc_standby_ctrl #(.FILTER_CYCLES(32'h8), .SHORT_CYCLES(32'h14), .LONG_CYCLES(32'h32)) u_dut (
		.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.modePin(modePin), .keyPins(keyPins), .irqIn(irqIn), .cpuReq(cpuReq),
		.cpuClkRun(cpuClkRun), .pcHold(pcHold), .oscRun(oscRun), .ctrlInit(ctrlInit),
		.modeResetOut(modeResetOut), .haltReleased(haltReleased), .irqTake(irqTake),
		.irqVector(irqVector), .keyPullDownEn(keyPullDownEn), .adcRouteSel(adcRouteSel));

	// ==========================================================
	// Pulse counters; single-cycle outputs are caught at the edge they stand
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (haltReleased === 1'b1) nRel <= nRel + 1;
		if (irqTake === 1'b1) nTake <= nTake + 1;
		if (irqTake === 1'b1) lastVec <= irqVector;
		if (modeResetOut === 1'b1) nMr <= nMr + 1;
		if (ctrlInit === 1'b1) nInit <= nInit + 1;
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		if (cyc == 20000) begin
			n_mismatch++;
			$display("[ERR] watchdog expected finish seen hang");
			wrap_up;
		end
	end

	// ==========================================================
	// Shared tasks
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// APB master: hold the request until pready is seen at an edge
	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= (idx == 8'hF0) ? idx : {idx[5:0], 2'b00};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task cpu(input shc_pkg::shc_cpu_req_t c);
		@(posedge ref_clk);
		cpuReq <= c;
		@(posedge ref_clk);
		cpuReq <= '0;
	endtask

	task halt(input logic [3:0] op);
		cpu('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, op});
	endtask

	task irqPulse(input logic [3:0] v);
		@(posedge ref_clk);
		irqIn <= v;
		@(posedge ref_clk);
		irqIn <= 4'h0;
	endtask

	task mode(input logic lvl, input int n);
		@(posedge ref_clk);
		modeCmd <= lvl;
		tick(n);
	endtask

	task automatic waitCnt(ref int c, input int goal, input int lim, input string what);
		int k;
		k = 0;
		while (c < goal && k < lim) begin
			@(posedge ref_clk);
			k++;
		end
		#1;
		chk(what, 32'(goal), 32'(c));
	endtask

	// ==========================================================
	// Scenarios
	task testReset;
		chk("cpuClkRun", 32'h1, 32'(cpuClkRun));
		chk("pcHold", 32'h0, 32'(pcHold));
		chk("oscRun", 32'h1, 32'(oscRun));
		chk("pullDown", 32'hF, 32'(keyPullDownEn));
		chk("adcRoute", 32'h0, 32'(adcRouteSel));
		apb(1'b0, 8'hF0, 32'h0);
		chk("unmappedErr", 32'h1, 32'(er));
		$display("test reset done");
	endtask

	task automatic testModeFilter;
		int mr;
		mode(1'b1, 5);
		mode(1'b0, 12);
		apb(1'b0, shc_pkg::IDX_MODE, 32'h0);
		chk("modeGlitch", 32'h0, rd & 32'h1);
		// Wait for the carry flag, clear it and select the long period so the arm check cannot race the next carry
		do apb(1'b0, shc_pkg::IDX_CARRY, 32'h0); while (rd[0] !== 1'b1);
		apb(1'b1, shc_pkg::IDX_CARRY, 32'h2);
		mr = nMr;
		mode(1'b1, 12);
		apb(1'b0, shc_pkg::IDX_MODE, 32'h0);
		chk("modeLevel", 32'h1, rd & 32'h1);
		apb(1'b0, shc_pkg::IDX_STATE, 32'h0);
		chk("resetArmed", 32'h40, rd & 32'h40);
		chk("noResetAtEdge", 32'(mr), 32'(nMr));
		waitCnt(nMr, mr + 1, 60, "modeReset");
		$display("test mode filter done");
	endtask

	task automatic testStopHalt;
		int ini;
		ini = nInit;
		cpu('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0});
		tick(3);
		chk("stopNop", 32'h1, 32'(oscRun));
		chk("stopNopInit", 32'(ini), 32'(nInit));
		halt(4'h0);
		tick(2);
		chk("haltHold", 32'h1, 32'(pcHold));
		chk("haltClk", 32'h0, 32'(cpuClkRun));
		keyDrv <= 4'hF;
		keyCmd <= 4'hF;
		tick(60);
		chk("haltOnlyReset", 32'h0, 32'(cpuClkRun));
		keyDrv <= 4'h0;
		mode(1'b0, 12);
		mode(1'b1, 2);
		waitCnt(nMr, nMr + 1, 80, "haltModeReset");
		tick(1);
		chk("haltResetRun", 32'h1, 32'(cpuClkRun));
		mode(1'b0, 12);
		cpu('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0});
		tick(2);
		chk("stopOsc", 32'h0, 32'(oscRun));
		chk("stopInit", 32'(ini + 1), 32'(nInit));
		mode(1'b1, 2);
		waitCnt(nMr, nMr + 1, 120, "stopModeReset");
		chk("stopWake", 32'h1, 32'(oscRun));
		$display("test stop and halt done");
	endtask

	task testKey;
		keyDrv <= 4'h4;
		keyCmd <= 4'h4;
		apb(1'b1, shc_pkg::IDX_KEY, 32'h50);
		tick(1);
		chk("routeSel", 32'h4, 32'(adcRouteSel));
		keyDrv <= 4'h0;
		apb(1'b0, shc_pkg::IDX_KEY, 32'h0);
		chk("routedLatch", 32'h4, rd & 32'hF);
		apb(1'b1, shc_pkg::IDX_KEY, 32'h0);
		halt(4'h1);
		tick(6);
		chk("keyNoRelease", 32'h0, 32'(cpuClkRun));
		keyCmd <= 4'h2;
		keyDrv <= 4'h2;
		waitCnt(nRel, nRel + 1, 6, "keyRelease");
		chk("keyRun", 32'h1, 32'(cpuClkRun));
		keyDrv <= 4'h0;
		$display("test key done");
	endtask

	task automatic testCarry;
		int t0;
		apb(1'b1, shc_pkg::IDX_CARRY, 32'h0);
		halt(4'h2);
		waitCnt(nRel, nRel + 1, 25, "carryRelease");
		apb(1'b0, shc_pkg::IDX_CARRY, 32'h0);
		chk("carryFlag", 32'h1, rd & 32'h1);
		apb(1'b1, shc_pkg::IDX_CARRY, 32'h2);
		halt(4'h2);
		waitCnt(nRel, nRel + 1, 60, "longRelease");
		t0 = cyc;
		halt(4'h2);
		waitCnt(nRel, nRel + 1, 60, "longRelease2");
		chk("longPeriod", 32'h32, 32'(cyc - t0));
		$display("test carry done");
	endtask

	task automatic testIrq;
		int rel;
		apb(1'b1, shc_pkg::IDX_IRQ_CTRL, 32'h6);
		// Enable then disable by instruction; global enable must read back clear
		cpu('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0});
		cpu('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0});
		apb(1'b0, shc_pkg::IDX_IRQ_CTRL, 32'h0);
		chk("diGie", 32'h6, rd & 32'h1F);
		irqPulse(4'h3);
		rel = nRel;
		halt(4'h8);
		tick(20);
		chk("noGieHold", 32'(rel), 32'(nRel));
		apb(1'b1, shc_pkg::IDX_IRQ_CTRL, 32'h7);
		waitCnt(nTake, nTake + 1, 6, "irqTake");
		chk("irqRelease", 32'(rel + 1), 32'(nRel));
		chk("firstVec", 32'(shc_pkg::SRC_EXT), 32'(lastVec));
		cpu('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0});
		cpu('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0});
		waitCnt(nTake, nTake + 1, 4, "timerAfterReturn");
		chk("secondVec", 32'(shc_pkg::SRC_TIMER), 32'(lastVec));
		cpu('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0});
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, shc_pkg::IDX_IRQ_CTRL, 32'h1F);
			rel = nRel;
			halt(4'h8);
			irqPulse(4'h1 << i);
			waitCnt(nTake, nTake + 1, 6, "srcTake");
			chk("srcVec", 32'(i), 32'(lastVec));
			chk("srcRelease", 32'(rel + 1), 32'(nRel));
			cpu('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0});
		end
		// Global enable on but external pin not permitted: pause must hold
		apb(1'b1, shc_pkg::IDX_IRQ_CTRL, 32'h1D);
		rel = nRel;
		halt(4'h8);
		irqPulse(4'h1);
		tick(6);
		chk("noPermHold", 32'(rel), 32'(nRel));
		$display("test interrupts done");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		tick(10);
		reset <= 1'b0;
		tick(1);
		testReset;
		testModeFilter;
		testStopHalt;
		testKey;
		testCarry;
		testIrq;
		wrap_up;
	end
endmodule
